// ---- hdl/sor_pkg.sv ----
// Purpose: constants, types and command table for the supported-opcode reporter
// Assumes: single clock, synchronous active-low reset
// Notes:   the timeout descriptor carries its length only, timeout values read zero
// Operation
// - request is operation byte A3h with service action 0Ch in byte 1.
// - timeouts request bit adds a timeouts descriptor except to an unsupported answer; clear adds none.
// - option 000b returns all supported commands; requested code fields ignored.
// - option 001b returns one-command data for the opcode; service action ignored.
// - option 001b on an opcode with service actions ends with invalid-field check.
// - option 010b uses opcode and service action; opcode without actions is an error.
// - option 011b reports supported for matching plain opcode with zero, or matching action.
// - option 011b otherwise reports support code 001b, never an error status.
// - requested opcode is byte 3, requested service action bytes 4 to 5.
// - data is cut to the allocation length in bytes 6 to 9, normal completion.
// - support codes: 000b unavailable, 001b unsupported, 011b standard, 101b vendor.
// - all-commands data opens with four-byte length, then one descriptor per command.
package sor_pkg;

    localparam logic [7:0]  SOR_OP_REPORT   = 8'hA3;
    localparam logic [4:0]  SOR_SA_REPORT   = 5'h0C;

    localparam logic [2:0]  SOR_OPT_ALL     = 3'h0;
    localparam logic [2:0]  SOR_OPT_OP      = 3'h1;
    localparam logic [2:0]  SOR_OPT_OP_SA   = 3'h2;
    localparam logic [2:0]  SOR_OPT_OP_SA_Q = 3'h3;

    localparam logic [2:0]  SOR_SUP_NA      = 3'h0;
    localparam logic [2:0]  SOR_SUP_NOT     = 3'h1;
    localparam logic [2:0]  SOR_SUP_STD     = 3'h3;
    localparam logic [2:0]  SOR_SUP_VEND    = 3'h5;

    localparam logic [7:0]  SOR_HDR_BYTES   = 8'h04;
    localparam logic [7:0]  SOR_DESC_BYTES  = 8'h08;
    localparam logic [7:0]  SOR_TMO_BYTES   = 8'h0C;
    localparam logic [7:0]  SOR_TMO_LEN     = 8'h0A;
    localparam logic [7:0]  SOR_ONE_BYTES   = 8'h04;
    localparam logic [7:0]  SOR_USAGE_FILL  = 8'hFF;

    localparam logic [3:0]  SOR_KEY_ILLEGAL = 4'h5;
    localparam logic [7:0]  SOR_ASC_INV_CDB = 8'h24;
    localparam logic [7:0]  SOR_ASCQ_INV    = 8'h00;

    localparam int          SOR_N_ENT       = 6;
    localparam int          SOR_IDX_W       = 3;

    typedef enum logic [2:0] {
        SOR_IDLE,
        SOR_SCAN,
        SOR_SCAN_CHK,
        SOR_HDR,
        SOR_FETCH,
        SOR_EMIT,
        SOR_DRAIN,
        SOR_FIN
    } sor_st_e;

    typedef struct packed {
        logic [7:0]  op;
        logic [2:0]  rsv1;
        logic [4:0]  sa;
        logic        return_timeouts_request;
        logic [3:0]  rsv2;
        logic [2:0]  opt;
        logic [7:0]  req_op;
        logic [15:0] req_sa;
        logic [31:0] alloc;
        logic [7:0]  rsv10;
        logic [7:0]  control;
    } sor_cdb_s;

    typedef struct packed {
        logic [7:0]  op;
        logic [15:0] sa;
        logic        has_sa;
        logic        vendor;
        logic [7:0]  cdb_len;
    } sor_ent_s;

    typedef struct packed {
        logic        check;
        logic [3:0]  sense_key;
        logic [7:0]  asc;
        logic [7:0]  ascq;
    } sor_status_s;

    typedef struct packed {
        sor_st_e                st;
        logic                   return_timeouts_request;
        logic [2:0]             opt;
        logic [7:0]             req_op;
        logic [15:0]            req_sa;
        logic [31:0]            alloc;
        logic [31:0]            sent;
        logic [SOR_IDX_W-1:0]   idx;
        logic [7:0]             pos;
        logic [7:0]             ulen;
        logic [31:0]            hdr_len;
        logic [2:0]             support;
        logic                   timeouts_descriptor_present;
        logic                   ready;
        logic                   tx_valid;
        logic [7:0]             tx_data;
        logic                   tx_last;
        logic                   done;
        sor_status_s            status;
    } sor_state_s;

    // supported commands, one entry per opcode and service action pair
    localparam sor_ent_s SOR_TABLE [SOR_N_ENT] = '{
        '{op: 8'h00, sa: 16'h0000, has_sa: 1'b0, vendor: 1'b0, cdb_len: 8'h06},
        '{op: 8'h12, sa: 16'h0000, has_sa: 1'b0, vendor: 1'b0, cdb_len: 8'h06},
        '{op: 8'h28, sa: 16'h0000, has_sa: 1'b0, vendor: 1'b0, cdb_len: 8'h0A},
        '{op: 8'h2A, sa: 16'h0000, has_sa: 1'b0, vendor: 1'b0, cdb_len: 8'h0A},
        '{op: 8'hA0, sa: 16'h0000, has_sa: 1'b0, vendor: 1'b0, cdb_len: 8'h0C},
        '{op: 8'hA3, sa: 16'h000C, has_sa: 1'b1, vendor: 1'b0, cdb_len: 8'h0C}
    };

endpackage

// ---- hdl/sor_cmd_rom.sv ----
// Purpose: command table with registered read data
// Assumes: address held stable for one cycle before data is used
// Notes:   one cycle read latency
`timescale 1ns/1ps
`default_nettype none
module sor_cmd_rom (
    input  wire logic                           i_core_clk,
    input  wire logic [sor_pkg::SOR_IDX_W-1:0]  i_addr,
    output sor_pkg::sor_ent_s                   o_ent
);
    import sor_pkg::*;

    always_ff @(posedge i_core_clk) begin
        o_ent <= SOR_TABLE[i_addr];
    end
endmodule
`default_nettype wire

// ---- hdl/sor_top.sv ----
// Purpose: decodes the supported-opcode report request and streams its parameter data
// Assumes: cdb presented whole for one cycle; byte sink uses valid/ready
// Notes:   commands other than the report request are left for other handlers
`timescale 1ns/1ps
`default_nettype none
module sor_top (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_cdb_valid,
    input  wire sor_pkg::sor_cdb_s      i_cdb,
    output logic                        o_cdb_ready,
    output logic                        o_tx_valid,
    output logic [7:0]                  o_tx_data,
    output logic                        o_tx_last,
    input  wire logic                   i_tx_ready,
    output logic                        o_done,
    output sor_pkg::sor_status_s        o_status
);
    import sor_pkg::*;

    sor_state_s q;
    sor_state_s d;
    sor_ent_s   rd;
    logic       take;
    logic       can_push;
    logic       hit;
    logic       last_idx;
    logic       err;
    logic       sup_ok;
    logic       fin_unit;
    logic       last_byte;

    sor_cmd_rom u_rom (
        .i_core_clk (i_core_clk),
        .i_addr     (q.idx),
        .o_ent      (rd)
    );

    function automatic logic [7:0] sor_tmo_byte(input logic [7:0] k);
        return (k == 8'h01) ? SOR_TMO_LEN : 8'h00;
    endfunction

    function automatic logic [7:0] sor_desc_byte(input logic [7:0] pos, input sor_ent_s e,
                                                 input logic timeouts_descriptor_present);
        logic [7:0] b;
        b = 8'h00;
        case (pos)
            8'h00: b = e.op;
            8'h02: b = e.sa[15:8];
            8'h03: b = e.sa[7:0];
            8'h05: b = {6'h00, timeouts_descriptor_present, e.has_sa};
            8'h07: b = e.cdb_len;
            default: begin
                if (pos >= SOR_DESC_BYTES) begin
                    b = sor_tmo_byte(8'(pos - SOR_DESC_BYTES));
                end
            end
        endcase
        return b;
    endfunction

    function automatic logic [7:0] sor_one_byte(input logic [7:0] pos, input sor_ent_s e,
                                                input logic timeouts_descriptor_present, input logic [2:0] sup);
        logic [7:0] b;
        logic [7:0] usage_end;
        b         = 8'h00;
        usage_end = 8'(SOR_ONE_BYTES + e.cdb_len);
        if (pos == 8'h01) begin
            b = {timeouts_descriptor_present, 4'h0, sup};
        end else if (pos == 8'h03) begin
            b = (sup == SOR_SUP_NOT) ? 8'h00 : e.cdb_len;
        end else if (pos == SOR_ONE_BYTES) begin
            b = e.op;
        end else if (pos > SOR_ONE_BYTES && pos < usage_end) begin
            b = (pos == 8'h05 && e.has_sa) ? {3'h0, e.sa[4:0]} : SOR_USAGE_FILL;
        end else if (pos >= usage_end) begin
            b = sor_tmo_byte(8'(pos - usage_end));
        end
        return b;
    endfunction

    assign take     = (q.st == SOR_IDLE) && i_cdb_valid && (i_cdb.op == SOR_OP_REPORT)
                      && (i_cdb.sa == SOR_SA_REPORT);
    assign can_push = !q.tx_valid || i_tx_ready;
    assign last_idx = (q.idx == SOR_IDX_W'(SOR_N_ENT - 1));
    // option 001b matches on opcode alone, the others also on the service action where the entry has one
    assign hit      = (rd.op == q.req_op) && ((q.opt == SOR_OPT_OP) || !rd.has_sa
                      || (rd.sa == q.req_sa));
    assign err      = hit && (((q.opt == SOR_OPT_OP) && rd.has_sa)
                      || ((q.opt == SOR_OPT_OP_SA) && !rd.has_sa));
    assign sup_ok   = hit && !((q.opt == SOR_OPT_OP_SA_Q) && !rd.has_sa
                      && (q.req_sa != 16'h0000));
    assign fin_unit = (8'(q.pos + 8'h01) == q.ulen);
    assign last_byte = (32'(q.sent + 32'h1) == q.alloc);

    always_comb begin
        d          = q;
        d.done     = 1'b0;
        d.tx_valid = q.tx_valid && !i_tx_ready;
        case (q.st)
            SOR_IDLE: begin
                d.ready = 1'b1;
                if (take) begin
                    d.ready   = 1'b0;
                    d.return_timeouts_request    = i_cdb.return_timeouts_request;
                    d.opt     = i_cdb.opt;
                    d.req_op  = i_cdb.req_op;
                    d.req_sa  = i_cdb.req_sa;
                    d.alloc   = i_cdb.alloc;
                    d.sent    = 32'h0;
                    d.idx     = '0;
                    d.pos     = 8'h00;
                    d.status  = '0;
                    d.timeouts_descriptor_present    = 1'b0;
                    d.support = SOR_SUP_NA;
                    if (i_cdb.opt[2]) begin
                        d.status = '{1'b1, SOR_KEY_ILLEGAL, SOR_ASC_INV_CDB, SOR_ASCQ_INV};
                        d.st     = SOR_FIN;
                    end else if (i_cdb.opt == SOR_OPT_ALL) begin
                        // requested code fields play no part here
                        d.timeouts_descriptor_present    = i_cdb.return_timeouts_request;
                        d.ulen    = i_cdb.return_timeouts_request ? 8'(SOR_DESC_BYTES + SOR_TMO_BYTES)
                                               : SOR_DESC_BYTES;
                        d.hdr_len = 32'(SOR_N_ENT) * 32'(d.ulen);
                        d.st      = (i_cdb.alloc == 32'h0) ? SOR_FIN : SOR_HDR;
                    end else begin
                        d.st = SOR_SCAN;
                    end
                end
            end
            SOR_SCAN: begin
                d.st = SOR_SCAN_CHK;
            end
            SOR_SCAN_CHK: begin
                if (err) begin
                    d.status = '{1'b1, SOR_KEY_ILLEGAL, SOR_ASC_INV_CDB, SOR_ASCQ_INV};
                    d.st     = SOR_FIN;
                end else if (hit || last_idx) begin
                    // a miss is answered with data, not with an error status
                    d.support = sup_ok ? (rd.vendor ? SOR_SUP_VEND : SOR_SUP_STD)
                                       : SOR_SUP_NOT;
                    d.timeouts_descriptor_present    = sup_ok && q.return_timeouts_request;
                    d.ulen    = sup_ok ? 8'(SOR_ONE_BYTES + rd.cdb_len
                                            + (q.return_timeouts_request ? SOR_TMO_BYTES : 8'h00))
                                       : SOR_ONE_BYTES;
                    d.st      = (q.alloc == 32'h0) ? SOR_FIN : SOR_FETCH;
                end else begin
                    d.idx = SOR_IDX_W'(q.idx + 1'b1);
                    d.st  = SOR_SCAN;
                end
            end
            SOR_HDR: begin
                if (can_push) begin
                    d.tx_valid = 1'b1;
                    d.tx_data  = 8'(q.hdr_len >> (8 * (3 - int'(q.pos[1:0]))));
                    d.tx_last  = last_byte;
                    d.sent     = 32'(q.sent + 32'h1);
                    if (last_byte) begin
                        d.st = SOR_DRAIN;
                    end else if (q.pos == 8'(SOR_HDR_BYTES - 8'h01)) begin
                        d.pos = 8'h00;
                        d.st  = SOR_FETCH;
                    end else begin
                        d.pos = 8'(q.pos + 8'h01);
                    end
                end
            end
            SOR_FETCH: begin
                d.st = SOR_EMIT;
            end
            SOR_EMIT: begin
                if (can_push) begin
                    d.tx_valid = 1'b1;
                    d.tx_data  = (q.opt == SOR_OPT_ALL) ? sor_desc_byte(q.pos, rd, q.timeouts_descriptor_present)
                                 : sor_one_byte(q.pos, rd, q.timeouts_descriptor_present, q.support);
                    d.tx_last  = last_byte || (fin_unit && ((q.opt != SOR_OPT_ALL)
                                 || last_idx));
                    d.sent     = 32'(q.sent + 32'h1);
                    if (d.tx_last) begin
                        d.st = SOR_DRAIN;
                    end else if (fin_unit) begin
                        d.pos = 8'h00;
                        d.idx = SOR_IDX_W'(q.idx + 1'b1);
                        d.st  = SOR_FETCH;
                    end else begin
                        d.pos = 8'(q.pos + 8'h01);
                    end
                end
            end
            SOR_DRAIN: begin
                if (can_push) begin
                    d.st = SOR_FIN;
                end
            end
            SOR_FIN: begin
                d.done  = 1'b1;
                d.ready = 1'b1;
                d.st    = SOR_IDLE;
            end
            default: begin
                d.st = SOR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_cdb_ready = q.ready;
    assign o_tx_valid  = q.tx_valid;
    assign o_tx_data   = q.tx_data;
    assign o_tx_last   = q.tx_last;
    assign o_done      = q.done;
    assign o_status    = q.status;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_check_end;
        (q.st == SOR_FIN) ##1 (o_done && o_status.check && !o_tx_valid);
    endsequence

    sequence s_take_all;
        take && (i_cdb.opt == SOR_OPT_ALL) && (i_cdb.alloc != 32'h0);
    endsequence

    a_decode_pair: assert property (
        (q.st == SOR_IDLE) && i_cdb_valid && !take |=> (q.st == SOR_IDLE))
        else $error("foreign command was taken");
    a_all_header: assert property (
        s_take_all |=> (q.st == SOR_HDR) && (q.hdr_len == 32'(SOR_N_ENT) * 32'(q.ulen)))
        else $error("all-commands header length wrong");
    a_all_list: assert property (
        s_take_all |=> (q.opt == SOR_OPT_ALL) && (q.idx == '0) ##4 (q.st != SOR_SCAN))
        else $error("all-commands request scanned the table");
    a_tmo_size: assert property (
        (q.st == SOR_EMIT) && (q.opt == SOR_OPT_ALL) |->
        (q.ulen == (q.return_timeouts_request ? 8'(SOR_DESC_BYTES + SOR_TMO_BYTES) : SOR_DESC_BYTES)))
        else $error("descriptor size does not follow timeouts request");
    a_no_timeouts_descriptor_present: assert property (
        (q.st != SOR_IDLE) && !q.return_timeouts_request |-> !q.timeouts_descriptor_present)
        else $error("timeouts descriptor present without request");
    a_reserved_opt: assert property (
        take && i_cdb.opt[2] |=> s_check_end)
        else $error("reserved option not rejected");
    a_opt1_sa_err: assert property (
        (q.st == SOR_SCAN_CHK) && (q.opt == SOR_OPT_OP) && (rd.op == q.req_op) && rd.has_sa
        |=> s_check_end)
        else $error("option 001b accepted opcode with service actions");
    a_opt2_nosa_err: assert property (
        (q.st == SOR_SCAN_CHK) && (q.opt == SOR_OPT_OP_SA) && (rd.op == q.req_op)
        && !rd.has_sa |=> s_check_end)
        else $error("option 010b accepted opcode without service actions");
    a_opt3_code: assert property (
        (q.st == SOR_SCAN_CHK) && (q.opt == SOR_OPT_OP_SA_Q) && hit && rd.has_sa
        |=> (q.support == SOR_SUP_STD) || (q.support == SOR_SUP_VEND))
        else $error("supported pair not reported supported");
    a_unsup_short: assert property (
        (q.st == SOR_FETCH) && (q.support == SOR_SUP_NOT) |-> (q.ulen == SOR_ONE_BYTES)
        && !q.status.check)
        else $error("unsupported answer malformed");
    a_alloc_cap: assert property (
        o_tx_valid |-> (q.sent <= q.alloc) && (o_tx_last == (q.sent == q.alloc)
        || o_tx_last))
        else $error("data beyond allocation length");
    a_trunc_good: assert property (
        o_tx_valid && o_tx_last && i_tx_ready |=> (q.st == SOR_FIN) ##1 (o_done
        && !o_status.check))
        else $error("truncated transfer not ended normally");

endmodule
`default_nettype wire

// ---- bench/sor_init_model.sv ----
// Purpose: initiator-side sink that collects the returned parameter data
// Assumes: one clock, a byte moves on an edge with valid and ready both high
// Notes:   slow mode drops ready every other cycle so held bytes get exercised
`timescale 1ns/1ps
`default_nettype none
module sor_init_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_slow,
    input  wire logic       i_clr,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_last,
    output logic            o_tx_ready
);
    logic [7:0] rx_q [256];
    int         n_rx;
    int         n_last;
    int         last_at;

    // ready does not wait for valid, as a real initiator buffer may not
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
        end
        if (!i_rst_n || i_clr) begin
            n_rx    <= 0;
            n_last  <= 0;
            last_at <= -1;
        end else if (i_tx_valid && o_tx_ready && n_rx < 256) begin
            rx_q[n_rx] <= i_tx_data;
            n_rx       <= n_rx + 1;
            if (i_tx_last) begin
                n_last  <= n_last + 1;
                last_at <= n_rx;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/sor_tb.sv ----
// Purpose: self-checking bench for the supported-opcode reporter
// Assumes: fixed six-entry command table, sink model on the byte stream
// Notes:   expected bytes are built here from an independent copy of the table
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module tb;
    import sor_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n    = 1'b0;
    logic        cdb_valid  = 1'b0;
    sor_cdb_s    cdb        = '0;
    logic        slow       = 1'b0;
    logic        clr        = 1'b0;
    logic        cdb_ready, tx_valid, tx_last, tx_ready, done;
    logic [7:0]  tx_data;
    sor_status_s status;
    int          n_errors   = 0;
    int          n_compared = 0;
    logic [7:0]  exp_q [$];
    localparam logic [7:0] T_OP  [6] = '{8'h00, 8'h12, 8'h28, 8'h2A, 8'hA0, 8'hA3};
    localparam logic [7:0] T_LEN [6] = '{8'h06, 8'h06, 8'h0A, 8'h0A, 8'h0C, 8'h0C};

    always #2 i_core_clk = ~i_core_clk;

    sor_top u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cdb_valid(cdb_valid),
        .i_cdb(cdb), .o_cdb_ready(cdb_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
        .o_tx_last(tx_last), .i_tx_ready(tx_ready), .o_done(done), .o_status(status));
    sor_init_model u_init (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_slow(slow),
        .i_clr(clr), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last),
        .o_tx_ready(tx_ready));

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    function automatic sor_cdb_s mk(input logic [2:0] opt, input logic rc,
            input logic [7:0] rop, input logic [15:0] rsa, input logic [31:0] al);
        return '{op: SOR_OP_REPORT, sa: SOR_SA_REPORT, return_timeouts_request: rc, opt: opt,
                 req_op: rop, req_sa: rsa, alloc: al, default: '0};
    endfunction

    function automatic void push_tmo();
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h0A);
        repeat (10) exp_q.push_back(8'h00);
    endfunction

    function automatic void push_all(input logic rc);
        exp_q = '{8'h00, 8'h00, 8'h00, rc ? 8'h78 : 8'h30};
        for (int i = 0; i < 6; i++) begin
            exp_q.push_back(T_OP[i]);
            exp_q.push_back(8'h00);
            exp_q.push_back(8'h00);
            exp_q.push_back(i == 5 ? 8'h0C : 8'h00);
            exp_q.push_back(8'h00);
            exp_q.push_back({6'h00, rc, i == 5});
            exp_q.push_back(8'h00);
            exp_q.push_back(T_LEN[i]);
            if (rc) push_tmo();
        end
    endfunction

    function automatic void push_one(input logic [7:0] op, input logic hs,
            input logic [4:0] sa, input logic [7:0] len, input logic rc);
        exp_q = '{8'h00, {rc, 4'h0, 3'h3}, 8'h00, len, op};
        for (int i = 1; i < len; i++) exp_q.push_back((i == 1 && hs) ? {3'h0, sa} : 8'hFF);
        if (rc) push_tmo();
    endfunction

    task automatic run(input sor_cdb_s c, input logic slw, input int max_wait,
            output logic seen);
        int k;
        @(negedge i_core_clk);
        clr  = 1'b1;
        slow = slw;
        @(negedge i_core_clk);
        clr = 1'b0;
        for (k = 0; k < 50 && cdb_ready !== 1'b1; k++) @(negedge i_core_clk);
        cdb       = c;
        cdb_valid = 1'b1;
        @(negedge i_core_clk);
        cdb_valid = 1'b0;
        seen = 1'b0;
        for (k = 0; k < max_wait && !seen; k++) begin
            @(posedge i_core_clk);
            #1;
            if (done === 1'b1) seen = 1'b1;
        end
    endtask

    // judges one finished command against exp_q and the status it should carry
    task automatic expect_data(input string what, input logic seen, input logic chk);
        `CHK({what, " done"}, 1'b1, seen)
        `CHK({what, " check"}, chk, status.check)
        `CHK({what, " ready"}, 1'b1, cdb_ready)
        `CHK({what, " count"}, exp_q.size(), u_init.n_rx)
        foreach (exp_q[i]) if (i < u_init.n_rx) `CHK(what, exp_q[i], u_init.rx_q[i])
        if (exp_q.size() > 0) begin
            `CHK({what, " last at"}, exp_q.size() - 1, u_init.last_at)
            `CHK({what, " last count"}, 1, u_init.n_last)
        end
        if (chk) begin
            `CHK({what, " key"}, SOR_KEY_ILLEGAL, status.sense_key)
            `CHK({what, " asc"}, SOR_ASC_INV_CDB, status.asc)
            `CHK({what, " ascq"}, SOR_ASCQ_INV, status.ascq)
        end
        $display("test %s done", what);
    endtask

    task automatic t_all();
        logic seen;
        push_all(1'b0);
        run(mk(3'h0, 1'b0, 8'h28, 16'h1234, 32'h1000), 1'b0, 600, seen);
        expect_data("all_list", seen, 1'b0);
        push_all(1'b1);
        run(mk(3'h0, 1'b1, 8'h00, 16'h0000, 32'h1000), 1'b1, 800, seen);
        expect_data("all_list_timeouts", seen, 1'b0);
    endtask

    task automatic t_trunc();
        logic seen;
        push_all(1'b0);
        exp_q = exp_q[0:4];
        run(mk(3'h0, 1'b0, 8'h00, 16'h0000, 32'h5), 1'b0, 200, seen);
        expect_data("truncated", seen, 1'b0);
        exp_q.delete();
        run(mk(3'h0, 1'b0, 8'h00, 16'h0000, 32'h0), 1'b0, 50, seen);
        expect_data("zero_alloc", seen, 1'b0);
    endtask

    task automatic t_single();
        logic     seen;
        sor_cdb_s c;
        // reserved and control bytes carry junk; the answer must not change
        c         = mk(3'h1, 1'b0, 8'h28, 16'hBEEF, 32'h1000);
        c.rsv1    = 3'h7;
        c.rsv2    = 4'hF;
        c.rsv10   = 8'hFF;
        c.control = 8'h04;
        push_one(8'h28, 1'b0, 5'h00, 8'h0A, 1'b0);
        run(c, 1'b0, 200, seen);
        expect_data("one_op", seen, 1'b0);
        exp_q.delete();
        run(mk(3'h1, 1'b0, 8'hA3, 16'h000C, 32'h1000), 1'b0, 200, seen);
        expect_data("one_op_has_sa", seen, 1'b1);
        run(mk(3'h2, 1'b0, 8'h28, 16'h0000, 32'h1000), 1'b0, 200, seen);
        expect_data("op_sa_plain", seen, 1'b1);
        push_one(8'hA3, 1'b1, 5'h0C, 8'h0C, 1'b1);
        run(mk(3'h2, 1'b1, 8'hA3, 16'h000C, 32'h1000), 1'b1, 400, seen);
        expect_data("op_sa", seen, 1'b0);
    endtask

    task automatic t_query();
        logic        seen;
        logic [7:0]  q_op  [5] = '{8'h12, 8'h12, 8'hA3, 8'hA3, 8'h55};
        logic [15:0] q_sa  [5] = '{16'h0000, 16'h0001, 16'h000C, 16'h0005, 16'h0000};
        logic        q_ok  [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [7:0]  q_len [5] = '{8'h06, 8'h06, 8'h0C, 8'h0C, 8'h00};
        for (int i = 0; i < 5; i++) begin
            if (q_ok[i]) push_one(q_op[i], i == 2, q_sa[i][4:0], q_len[i], 1'b0);
            else exp_q = '{8'h00, 8'h01, 8'h00, 8'h00};
            run(mk(3'h3, 1'b0, q_op[i], q_sa[i], 32'h1000), 1'b0, 200, seen);
            expect_data("query", seen, 1'b0);
        end
    endtask

    // reset lands in the middle of a descriptor list; block must come back idle
    task automatic t_reset();
        logic seen;
        push_all(1'b0);
        run(mk(3'h0, 1'b0, 8'h00, 16'h0000, 32'h1000), 1'b0, 20, seen);
        @(negedge i_core_clk);
        `CHK("busy ready", 1'b0, cdb_ready)
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        `CHK("reset valid", 1'b0, tx_valid)
        `CHK("reset done", 1'b0, done)
        `CHK("reset ready", 1'b0, cdb_ready)
        i_rst_n = 1'b1;
        push_one(8'h12, 1'b0, 5'h00, 8'h06, 1'b0);
        run(mk(3'h3, 1'b0, 8'h12, 16'h0000, 32'h1000), 1'b0, 200, seen);
        expect_data("after_reset", seen, 1'b0);
    endtask

    task automatic t_reserved();
        logic seen;
        exp_q.delete();
        for (int o = 4; o < 8; o++) begin
            run(mk(o[2:0], 1'b1, 8'h28, 16'h0000, 32'h1000), 1'b0, 50, seen);
            expect_data("reserved_option", seen, 1'b1);
        end
    endtask

    task automatic t_ignored();
        logic     seen;
        sor_cdb_s c;
        c    = mk(3'h0, 1'b0, 8'h00, 16'h0000, 32'h1000);
        c.op = 8'h12;
        run(c, 1'b0, 40, seen);
        `CHK("other opcode done", 1'b0, seen)
        `CHK("other opcode ready", 1'b1, cdb_ready)
        c.op = SOR_OP_REPORT;
        c.sa = 5'h0D;
        run(c, 1'b0, 40, seen);
        `CHK("other action done", 1'b0, seen)
        `CHK("ignored bytes", 0, u_init.n_rx)
        $display("test ignored done");
    endtask

    initial begin
        repeat (4) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        t_all();
        t_trunc();
        t_single();
        t_query();
        t_reset();
        t_reserved();
        t_ignored();
        conclude();
    end

    // whole run needs well under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
